// >>> verilog/lds_regs.vh
`ifndef LDS_REGS_VH
`define LDS_REGS_VH

// Frame geometry.
`define LDS_WORD_BITS 16
`define LDS_ADDR_MSB 15
`define LDS_ADDR_LSB 12
`define LDS_CNT_BITS 4

// Control and status register addresses carried in the upper nibble of a frame.
`define LDS_ADDR_INIT 4'h0
`define LDS_ADDR_CH1 4'h1
`define LDS_ADDR_CH2 4'h2
`define LDS_ADDR_STATUS1 4'h1

// Control register reset values.
`define LDS_RST_INIT 16'h0001
`define LDS_RST_CH1 16'h1000
`define LDS_RST_CH2 16'h2000

// Field positions in the initialization register.
`define LDS_BIT_OUT_ADDR_LSB 0
`define LDS_BIT_READBACK 9
`define LDS_BIT_TOGGLE 11

// Field positions in status register 1.
`define LDS_BIT_WD_ERR 1
`define LDS_BIT_FRAME_ERR 5

// Timing: clock rate and supervision times.
`define LDS_CLK_MHZ 100
`define LDS_CS_TIMEOUT_US 1000
`define LDS_WD_TIMEOUT_US 50000
`define LDS_CS_TIMEOUT_CYC (`LDS_CS_TIMEOUT_US * `LDS_CLK_MHZ)
`define LDS_WD_TIMEOUT_CYC (`LDS_WD_TIMEOUT_US * `LDS_CLK_MHZ)

`endif

// >>> verilog/lds_pin_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser; a new level is taken once stages two and three agree.
module lds_pin_sync #(
    parameter RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Pin and filtered level
    input wire i_pin,
    output reg o_level
);

    reg meta_reg;
    reg stage2_reg;
    reg stage3_reg;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
            o_level <= RESET_LEVEL;
        end else begin
            meta_reg <= i_pin;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                o_level <= stage3_reg;
            end
        end
    end

endmodule

// >>> verilog/lds_spi_slave.v
`timescale 1ns/1ps
`include "lds_regs.vh"

module lds_spi_slave #(
    parameter [31:0] CS_TIMEOUT_CYCLES = `LDS_CS_TIMEOUT_CYC,
    parameter [31:0] WD_TIMEOUT_CYCLES = `LDS_WD_TIMEOUT_CYC
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Serial link pins
    input wire i_chip_select_n,
    input wire i_sck,
    input wire i_sdi,
    output reg o_sdo,
    output reg o_sdo_oe,
    // Control register contents
    output reg [15:0] o_initialization_control,
    output reg [15:0] o_channel_one_control,
    output reg [15:0] o_channel_two_control,
    // Supervision state
    output reg o_fail_mode,
    output reg o_frame_error_flag,
    output reg o_watchdog_timeout_error
);

    wire cs_n_level;
    wire sck_level;
    wire sdi_level;
    reg cs_n_prev_reg;
    reg sck_prev_reg;
    reg [15:0] shift_reg;
    reg [15:0] shift_next;
    reg [`LDS_CNT_BITS-1:0] bit_cnt_reg;
    reg any_clock_reg;
    reg seen_zero_reg;
    reg seen_one_reg;
    reg [31:0] cs_cnt_reg;
    reg cs_timeout_reg;
    reg [31:0] wd_cnt_reg;
    reg toggle_expect_reg;
    reg [3:0] last_addr_reg;
    wire cs_fall;
    wire cs_rise;
    wire sck_rise;
    wire sck_fall;
    wire count_bad;
    wire data_stuck;
    wire frame_valid;
    wire frame_error_set;
    wire wd_expired;
    wire [3:0] rx_addr;

    lds_pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_sync_cs (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_chip_select_n),
        .o_level(cs_n_level)
    );

    lds_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sync_sck (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_sck),
        .o_level(sck_level)
    );

    lds_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sync_sdi (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_sdi),
        .o_level(sdi_level)
    );

    // Selects the stored control word for an address; unknown addresses read as zero.
    function [15:0] lds_ctrl_word;
        input [3:0] addr;
        input [15:0] init_word;
        input [15:0] ch1_word;
        input [15:0] ch2_word;
        begin
            case (addr)
                `LDS_ADDR_INIT: lds_ctrl_word = init_word;
                `LDS_ADDR_CH1: lds_ctrl_word = ch1_word;
                `LDS_ADDR_CH2: lds_ctrl_word = ch2_word;
                default: lds_ctrl_word = 16'h0000;
            endcase
        end
    endfunction

    assign cs_fall = cs_n_prev_reg && !cs_n_level;
    assign cs_rise = !cs_n_prev_reg && cs_n_level;
    // Clock edges come from the synchronised level, so the link clock must stay well
    // below a quarter of the system clock rate or edges are lost.
    // edges only inside frame
    assign sck_rise = !cs_n_level && !cs_n_prev_reg && !sck_prev_reg && sck_level;
    assign sck_fall = !cs_n_level && !cs_n_prev_reg && sck_prev_reg && !sck_level;

    assign count_bad = (bit_cnt_reg != 4'h0);
    assign data_stuck = any_clock_reg && !(seen_zero_reg && seen_one_reg);
    assign frame_valid = cs_rise && any_clock_reg && !count_bad && !data_stuck && !cs_timeout_reg;
    assign frame_error_set = cs_rise && any_clock_reg && (count_bad || data_stuck);
    assign wd_expired = (wd_cnt_reg == WD_TIMEOUT_CYCLES - 32'h0000_0001);
    assign rx_addr = shift_reg[`LDS_ADDR_MSB:`LDS_ADDR_LSB];

    // The shift register keeps serving as the status load target, the receive
    // register and the daisy-chain delay line, so passed-through words lag 16 clocks.
    always @* begin
        shift_next = shift_reg;
        if (cs_fall) begin
            if (o_initialization_control[`LDS_BIT_READBACK]) begin
                shift_next = lds_ctrl_word(last_addr_reg, o_initialization_control,
                    o_channel_one_control, o_channel_two_control);
            end else begin
                shift_next = {`LDS_ADDR_STATUS1, 12'h000};
                shift_next[`LDS_BIT_FRAME_ERR] = o_frame_error_flag;
                shift_next[`LDS_BIT_WD_ERR] = o_watchdog_timeout_error;
            end
        end else if (sck_fall) begin
            shift_next = {shift_reg[14:0], sdi_level};
        end
    end

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_n_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
            shift_reg <= 16'h0000;
        end else begin
            cs_n_prev_reg <= cs_n_level;
            sck_prev_reg <= sck_level;
            shift_reg <= shift_next;
        end
    end

    // Frame bookkeeping: clock count, data content and select-low time.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_cnt_reg <= 4'h0;
            any_clock_reg <= 1'b0;
            seen_zero_reg <= 1'b0;
            seen_one_reg <= 1'b0;
            cs_cnt_reg <= 32'h0000_0000;
            cs_timeout_reg <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 4'h0;
            any_clock_reg <= 1'b0;
            seen_zero_reg <= 1'b0;
            seen_one_reg <= 1'b0;
            cs_cnt_reg <= 32'h0000_0000;
            cs_timeout_reg <= 1'b0;
        end else begin
            if (sck_fall) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                any_clock_reg <= 1'b1;
                if (sdi_level) begin
                    seen_one_reg <= 1'b1;
                end else begin
                    seen_zero_reg <= 1'b1;
                end
            end
            if (!cs_n_level && !cs_timeout_reg) begin
                if (cs_cnt_reg == CS_TIMEOUT_CYCLES - 32'h0000_0001) begin
                    cs_timeout_reg <= 1'b1;
                end else begin
                    cs_cnt_reg <= cs_cnt_reg + 32'h0000_0001;
                end
            end
        end
    end

    // SDO is driven only while selected; a stuck-low select releases the shared line.
    // Each new bit appears about five system clocks after the clock pin rises, so a
    // master must read late in the clock period; this is the price of pin oversampling.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            if (cs_fall) begin
                // A timeout flag left from the previous frame must not delay the enable.
                o_sdo_oe <= 1'b1;
            end else begin
                o_sdo_oe <= !cs_n_level && !cs_timeout_reg;
            end
            if (cs_fall) begin
                o_sdo <= shift_next[15];
            end else if (sck_rise) begin
                o_sdo <= shift_reg[15];
            end
        end
    end

    // Control registers, written only at the close of a clean frame.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_initialization_control <= `LDS_RST_INIT;
            o_channel_one_control <= `LDS_RST_CH1;
            o_channel_two_control <= `LDS_RST_CH2;
            last_addr_reg <= `LDS_ADDR_INIT;
        end else if (frame_valid) begin
            last_addr_reg <= rx_addr;
            case (rx_addr)
                `LDS_ADDR_INIT: o_initialization_control <= shift_reg;
                `LDS_ADDR_CH1: o_channel_one_control <= shift_reg;
                `LDS_ADDR_CH2: o_channel_two_control <= shift_reg;
                default: last_addr_reg <= rx_addr;
            endcase
        end
    end

    // The toggle is checked on initialization writes only; a wrong toggle value
    // is not counted as a refresh, so the timer keeps running toward the error.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wd_cnt_reg <= 32'h0000_0000;
            toggle_expect_reg <= 1'b0;
        end else begin
            if (frame_valid && rx_addr == `LDS_ADDR_INIT
                    && shift_reg[`LDS_BIT_TOGGLE] == toggle_expect_reg) begin
                wd_cnt_reg <= 32'h0000_0000;
                toggle_expect_reg <= !toggle_expect_reg;
            end else if (wd_expired) begin
                wd_cnt_reg <= 32'h0000_0000;
            end else begin
                wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Error flags clear when shipped out as status; a new error in that cycle wins.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame_error_flag <= 1'b0;
            o_watchdog_timeout_error <= 1'b0;
            o_fail_mode <= 1'b0;
        end else begin
            if (frame_error_set) begin
                o_frame_error_flag <= 1'b1;
            end else if (cs_fall && !o_initialization_control[`LDS_BIT_READBACK]) begin
                o_frame_error_flag <= 1'b0;
            end
            if (wd_expired) begin
                o_watchdog_timeout_error <= 1'b1;
            end else if (cs_fall && !o_initialization_control[`LDS_BIT_READBACK]) begin
                o_watchdog_timeout_error <= 1'b0;
            end
            if (frame_error_set || wd_expired) begin
                o_fail_mode <= 1'b1;
            end else if (!o_frame_error_flag && !o_watchdog_timeout_error) begin
                o_fail_mode <= 1'b0;
            end
        end
    end

endmodule

// >>> testbench/lds_spi_slave_properties.sv
`timescale 1ns/1ps
module lds_spi_slave_properties #(
    parameter [31:0] CS_TIMEOUT_CYCLES = 32'd2000,
    parameter [31:0] WD_TIMEOUT_CYCLES = 32'd5000
) (
    // Watched design ports.
    input wire i_clk,
    input wire i_reset_n,
    input wire i_chip_select_n,
    input wire i_sck,
    input wire i_sdi,
    input wire o_sdo,
    input wire o_sdo_oe,
    input wire [15:0] o_initialization_control,
    input wire [15:0] o_channel_one_control,
    input wire [15:0] o_channel_two_control,
    input wire o_fail_mode,
    input wire o_frame_error_flag,
    input wire o_watchdog_timeout_error
);
    reg cs_d;
    reg sck_d;
    reg [7:0] rise_age;
    reg [7:0] sck_age;
    reg [31:0] low_cnt;
    // Ages saturate so that a long idle span cannot wrap back into a window.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_d <= 1'b1;
            sck_d <= 1'b0;
            rise_age <= 8'hff;
            sck_age <= 8'hff;
            low_cnt <= 32'h0000_0000;
        end else begin
            cs_d <= i_chip_select_n;
            sck_d <= i_sck;
            rise_age <= (i_chip_select_n & ~cs_d) ? 8'h01 : rise_age + {7'h00, rise_age != 8'hff};
            sck_age <= (i_sck & ~sck_d) ? 8'h01 : sck_age + {7'h00, sck_age != 8'hff};
            low_cnt <= i_chip_select_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_idle_float: assert property (i_chip_select_n [*8] |-> !o_sdo_oe)
        else $error("sdo driven while deselected");
    a_select_drives: assert property ($fell(i_chip_select_n) |-> ##[3:8] o_sdo_oe)
        else $error("sdo not driven after select fall");
    a_write_at_rise: assert property ($changed({o_initialization_control, o_channel_one_control,
        o_channel_two_control}) |-> rise_age >= 8'h02 && rise_age <= 8'h09)
        else $error("register changed away from select rise");
    a_err_sets_fail: assert property ($rose(o_frame_error_flag) |-> ##[0:1] o_fail_mode)
        else $error("frame error without fail state");
    a_wd_sets_fail: assert property ($rose(o_watchdog_timeout_error) |-> ##[0:1] o_fail_mode)
        else $error("watchdog error without fail state");
    a_err_at_end: assert property ($rose(o_frame_error_flag) |-> rise_age >= 8'h02 && rise_age <= 8'h09)
        else $error("frame error away from frame end");
    a_fail_clears: assert property (o_fail_mode && !o_frame_error_flag && !o_watchdog_timeout_error
        |-> ##[1:2] (!o_fail_mode || o_frame_error_flag || o_watchdog_timeout_error))
        else $error("fail state stuck without cause");
    a_cs_timeout: assert property (low_cnt > CS_TIMEOUT_CYCLES + 32'd8 |-> !o_sdo_oe)
        else $error("sdo driven after select timeout");
    a_sdo_on_rise: assert property ($changed(o_sdo) && o_sdo_oe && $past(o_sdo_oe)
        |-> sck_age >= 8'h02 && sck_age <= 8'h09)
        else $error("sdo moved without clock rise");
endmodule
bind lds_spi_slave lds_spi_slave_properties #(
    .CS_TIMEOUT_CYCLES(CS_TIMEOUT_CYCLES), .WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)
) u_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_chip_select_n(i_chip_select_n), .i_sck(i_sck),
    .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_initialization_control(o_initialization_control),
    .o_channel_one_control(o_channel_one_control), .o_channel_two_control(o_channel_two_control),
    .o_fail_mode(o_fail_mode), .o_frame_error_flag(o_frame_error_flag),
    .o_watchdog_timeout_error(o_watchdog_timeout_error)
);

// >>> testbench/lds_spi_master_model.sv
`timescale 1ns/1ps
module lds_spi_master_model (
    input wire i_clk,
    input wire i_sdo_line,
    output reg o_chip_select_n,
    output reg o_sck,
    output reg o_sdi
);
    initial begin
        o_chip_select_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    // The slave moves its output about five system clocks after each clock rise, which is later
    // than the following fall at this clock rate. Each bit is therefore read at the end of its own
    // clock period, just before the next rise.
    task automatic xfer(input integer n, input [31:0] tx, input integer pre, output [31:0] rx);
        integer i;
        begin
            rx = 32'h0000_0000;
            @(posedge i_clk);
            o_chip_select_n <= 1'b0;
            repeat (8 + pre) @(posedge i_clk);
            // n bits from tx, top bit first, data set at clock rise.
            for (i = n - 1; i >= 0; i = i - 1) begin
                o_sck <= 1'b1;
                o_sdi <= tx[i];
                repeat (4) @(posedge i_clk);
                o_sck <= 1'b0;
                repeat (4) @(posedge i_clk);
                rx[i] = i_sdo_line;
            end
            // clock low at select change; data is driven back to zero.
            o_chip_select_n <= 1'b1;
            o_sdi <= 1'b0;
            repeat (8) @(posedge i_clk);
        end
    endtask
endmodule

// >>> testbench/lds_spi_slave_bench.sv
`timescale 1ns/1ps
module lds_spi_slave_bench;
    localparam [31:0] CS_TO = 32'd2000;
    localparam [31:0] WD_TO = 32'd5000;
    reg i_clk;
    reg i_reset_n;
    reg tog;
    reg [15:0] init_exp;
    reg [31:0] rx;
    integer n_mismatch;
    integer checked;
    integer k;
    wire cs_n, sck, sdi, sdo, oe, fail, ferr, wderr, sdo_line;
    wire [15:0] init_q, ch1_q, ch2_q;
    assign sdo_line = oe ? sdo : 1'bz;
    lds_spi_slave #(.CS_TIMEOUT_CYCLES(CS_TO), .WD_TIMEOUT_CYCLES(WD_TO)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_chip_select_n(cs_n), .i_sck(sck), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe(oe), .o_initialization_control(init_q), .o_channel_one_control(ch1_q),
        .o_channel_two_control(ch2_q), .o_fail_mode(fail), .o_frame_error_flag(ferr),
        .o_watchdog_timeout_error(wderr));
    lds_spi_master_model m (.i_clk(i_clk), .i_sdo_line(sdo_line), .o_chip_select_n(cs_n), .o_sck(sck),
        .o_sdi(sdi));
    task chk(input [15:0] act, input [15:0] exp);
        begin
            checked = checked + 1;
            if (act !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t got %h want %h", $time, act, exp);
            end
        end
    endtask
    // toggle bit starts at zero after reset and flips on every accepted initialization write.
    task wr_init(input [15:0] w);
        begin
            init_exp = w | {4'h0, tog, 11'h000};
            m.xfer(16, {16'h0000, init_exp}, 0, rx);
            tog = ~tog;
        end
    endtask
    task t_wd;
        begin
            repeat (WD_TO + 100) @(posedge i_clk);
            chk({14'h0000, wderr, fail}, 16'h0003);
            wr_init(16'h0001);
            chk(rx[15:0], 16'h1002);
            chk({14'h0000, wderr, fail}, 16'h0000);
        end
    endtask
    task t_daisy;
        begin
            m.xfer(32, {16'h2ABC, 16'h1456}, 0, rx);
            chk(rx[31:16], 16'h1000);
            chk(rx[15:0], 16'h2ABC);
            chk(ch1_q, 16'h1456);
            chk(ch2_q, 16'h2000);
        end
    endtask
    task t_count;
        begin
            m.xfer(15, 32'h0000_2111, 0, rx);
            chk(ch2_q, 16'h2000);
            chk({14'h0000, ferr, fail}, 16'h0003);
            m.xfer(16, 32'h0000_2222, 0, rx);
            chk(rx[15:0], 16'h1020);
            chk(ch2_q, 16'h2222);
        end
    endtask
    task t_stuck;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                m.xfer(16, k ? 32'h0000_FFFF : 32'h0000_0000, 0, rx);
                chk(init_q, init_exp);
                chk({15'h0000, ferr}, 16'h0001);
                m.xfer(16, 32'h0000_1333, 0, rx);
                chk(rx[15:0], 16'h1020);
            end
        end
    endtask
    task t_readback;
        begin
            wr_init(16'h0201);
            m.xfer(16, 32'h0000_2345, 0, rx);
            chk(rx[15:0], init_exp);
            wr_init(16'h0001);
            chk(rx[15:0], 16'h2345);
        end
    endtask
    task t_timeout;
        begin
            wr_init(16'h0001);
            m.xfer(16, 32'h0000_1777, CS_TO + 100, rx);
            chk(rx[15:0], 16'hzzzz);
            chk(ch1_q, 16'h1333);
            wr_init(16'h0001);
            chk(rx[15:0], 16'h1000);
        end
    endtask
    task final_report;
        begin
            if (n_mismatch == 0 && checked > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_reset_n = 1'b0;
        n_mismatch = 0;
        checked = 0;
        tog = 1'b0;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(init_q, 16'h0001);
        chk(ch1_q, 16'h1000);
        chk(ch2_q, 16'h2000);
        chk({15'h0000, oe}, 16'h0000);
        t_wd;
        t_daisy;
        t_count;
        t_stuck;
        t_readback;
        t_timeout;
        final_report;
    end
    // The whole sequence needs about 94 us, so this only trips on a hang.
    initial begin
        #300000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
endmodule
